// >>> hdl/ufl_consts.vh
`ifndef UFL_CONSTS_VH
`define UFL_CONSTS_VH

// Register byte offsets
`define UFL_OFF_CTRL     12'h000
`define UFL_OFF_BAUD     12'h004
`define UFL_OFF_PINSEL   12'h008
`define UFL_OFF_STATUS   12'h00C
`define UFL_OFF_IRQ      12'h010
`define UFL_OFF_MASK     12'h014
`define UFL_OFF_TXPTR    12'h018
`define UFL_OFF_TXCNT    12'h01C
`define UFL_OFF_RXPTR    12'h020
`define UFL_OFF_RXCNT    12'h024
`define UFL_OFF_TXDATA   12'h028
`define UFL_OFF_RXDATA   12'h02C
`define UFL_OFF_START    12'h030

// Control fields
`define UFL_CTRL_EN      0
`define UFL_CTRL_FLOW    1
`define UFL_CTRL_PARITY  2
`define UFL_CTRL_ODD     3
`define UFL_CTRL_STOP2   4

// Start register fields
`define UFL_START_TX     0
`define UFL_START_RX     1

// Interrupt fields
`define UFL_IRQ_TXDONE   0
`define UFL_IRQ_RXRDY    1
`define UFL_IRQ_PARERR   2
`define UFL_IRQ_FRMERR   3
`define UFL_IRQ_OVRRUN   4
`define UFL_IRQ_DMATX    5
`define UFL_IRQ_DMARX    6
`define UFL_IRQ_W        7

// Reset values
`define UFL_CTRL_RST     5'h00
`define UFL_PINSEL_RST   8'hE4
`define UFL_STATUS_W     8

// Timing: fastest rate 1 Mbit/s at 100 MHz clock
`define UFL_CLK_HZ       100000000
`define UFL_MAX_BAUD     1000000
`define UFL_MIN_DIV      (`UFL_CLK_HZ / `UFL_MAX_BAUD)
`define UFL_BAUD_RST     16'h0364
`define UFL_BAUD_MIN     16'h0064

`endif

// >>> hdl/ufl_tx.v
`timescale 1ns/10ps
`default_nettype none
`include "ufl_consts.vh"

module ufl_tx (
  input  wire        clk,
  input  wire        rst_n,
  input  wire        bit_tick,
  input  wire        parity_en,
  input  wire        parity_odd,
  input  wire        stop2,
  input  wire        flow_en,
  input  wire        cts_n,
  input  wire        load,
  input  wire [7:0]  data,
  output reg         busy,
  output reg         done,
  output reg         line
);

  reg [3:0] nbits;
  reg [3:0] idx;
  reg [10:0] shreg;

  always @(posedge clk) begin
    if (!rst_n) begin
      busy  <= 1'b0;
      done  <= 1'b0;
      line  <= 1'b1;
      nbits <= 4'h0;
      idx   <= 4'h0;
      shreg <= 11'h7FF;
    end else begin
      done <= 1'b0;
      if (!busy) begin
        line <= 1'b1;
        // With flow control on, start only while the far side grants, see R04
        if (load && (!flow_en || !cts_n)) begin
          busy  <= 1'b1;
          idx   <= 4'h0;
          // Start, data lsb first, optional parity, stops, see R01 see R05 see R06
          shreg <= parity_en ?
                   {2'b11, ^data ^ parity_odd, data} : {3'b111, data};
          nbits <= 4'd9 + {3'b000, parity_en} + {3'b000, stop2};
          line  <= 1'b0;
        end
      end else if (bit_tick) begin
        if (idx == nbits) begin
          busy <= 1'b0;
          done <= 1'b1;
          line <= 1'b1;
        end else begin
          line  <= shreg[0];
          shreg <= {1'b1, shreg[10:1]};
          idx   <= idx + 4'h1;
        end
      end
    end
  end

endmodule // ufl_tx

`default_nettype wire

// >>> hdl/ufl_top.v
// What this block does
// R01 - Transmit and receive run independently at once, each character lsb first.
// R02 - The bit rate is programmable, up to one megabit per second, same on both ends.
// R03 - With flow control on, request-to-send is low while the receiver can take data.
// R04 - With flow control on, a character starts only while clear-to-send is low.
// R05 - With parity on, a parity ninth bit is sent, and checked on receive with error report.
// R06 - Each sent frame ends in one or two stop bits, as selected.
// R07 - Pin assignments are written while disabled and reach the pins only once enabled.
// R08 - The transmit line is an output to the far receiver; receive is an input from it.
// R09 - A memory access path fetches bytes to send and stores bytes received.
// R10 - Software programs all settings before enabling and disables sharing peripherals.
// R11 - The receiver finds the start edge and samples each bit at its centre.
`timescale 1ns/10ps
`default_nettype none
`include "ufl_consts.vh"

module ufl_top (
  input  wire        CLOCK,
  input  wire        RST_N,
  input  wire        PSEL,
  input  wire        PENABLE,
  input  wire        PWRITE,
  input  wire [11:0] PADDR,
  input  wire [31:0] PWDATA,
  output reg  [31:0] PRDATA,
  output reg         PREADY,
  output reg         PSLVERR,
  output reg         IRQ,
  input  wire [3:0]  PIN_IN,
  output reg  [3:0]  PIN_OUT,
  output reg  [3:0]  PIN_OE,
  output reg         MEM_REQ,
  output reg         MEM_WE,
  output reg  [31:0] MEM_ADDR,
  output reg  [7:0]  MEM_WDATA,
  input  wire [7:0]  MEM_RDATA,
  input  wire        MEM_ACK
);

  // Pin select: two bits per signal, order tx, rx, rts, cts
  function [1:0] psel_of;
    input [7:0] map;
    input [1:0] sig;
    begin
      psel_of = map[sig*2 +: 2];
    end
  endfunction

  reg  [4:0]  ctrl;
  reg  [15:0] baud;
  reg  [7:0]  pinsel;
  reg  [7:0]  pinsel_live;
  reg  [`UFL_IRQ_W-1:0] irq_st;
  reg  [`UFL_IRQ_W-1:0] irq_mask;
  reg  [31:0] tx_ptr;
  reg  [15:0] tx_cnt;
  reg  [31:0] rx_ptr;
  reg  [15:0] rx_cnt;
  reg  [7:0]  tx_hold;
  reg         tx_full;
  reg  [7:0]  rx_hold;
  reg         rx_full;
  reg         dma_tx_on;
  reg         dma_rx_on;
  reg  [1:0]  mem_op;
  wire        en = ctrl[`UFL_CTRL_EN];
  wire        wr = PSEL & PENABLE & PWRITE & ~PREADY;
  wire        rd = PSEL & PENABLE & ~PWRITE & ~PREADY;

  ////////////////////////////////////////////////////////////////////////
  // Bit-rate ticks: one per bit for send, sixteen per bit for receive
  reg  [15:0] tx_div;
  reg         tx_tick;
  reg  [11:0] rx_div;
  reg         rx_tick;
  wire        tx_busy;
  wire [15:0] baud_eff = (baud < `UFL_BAUD_MIN) ? `UFL_BAUD_MIN : baud; // see R02

  always @(posedge CLOCK) begin
    if (!RST_N || !en) begin
      tx_div  <= 16'h0000;
      tx_tick <= 1'b0;
      rx_div  <= 12'h000;
      rx_tick <= 1'b0;
    end else begin
      // Send divider restarts with each frame so the start bit lasts a full bit
      if (!tx_busy) begin
        tx_div  <= 16'h0000;
        tx_tick <= 1'b0;
      end else begin
        tx_tick <= (tx_div == baud_eff - 16'h0001);
        tx_div  <= (tx_div == baud_eff - 16'h0001) ? 16'h0000 : tx_div + 16'h0001;
      end
      rx_tick <= (rx_div == baud_eff[15:4] - 12'h001);
      rx_div  <= (rx_div == baud_eff[15:4] - 12'h001) ? 12'h000 : rx_div + 12'h001;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Pin routing, live map only follows the written one while disabled
  wire rxd_in;
  wire cts_n_in;
  wire tx_line;
  wire rts_n = ~(~rx_full & en);  // see R03
  assign rxd_in   = PIN_IN[psel_of(pinsel_live, 2'd1)];  // see R08
  assign cts_n_in = PIN_IN[psel_of(pinsel_live, 2'd3)];

  integer k;
  always @(posedge CLOCK) begin
    if (!RST_N) begin
      pinsel_live <= `UFL_PINSEL_RST;
      PIN_OUT     <= 4'h0;
      PIN_OE      <= 4'h0;
    end else begin
      if (!en)
        pinsel_live <= pinsel;  // see R07
      for (k = 0; k < 4; k = k + 1) begin
        PIN_OE[k]  <= en & ((psel_of(pinsel_live, 2'd0) == k[1:0]) |
                      (ctrl[`UFL_CTRL_FLOW] & (psel_of(pinsel_live, 2'd2) == k[1:0]))); // see R07
        PIN_OUT[k] <= (psel_of(pinsel_live, 2'd0) == k[1:0]) ? tx_line : rts_n; // see R08
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Transmitter
  wire tx_done;
  // With flow control on, the held byte is only handed over once the far side grants, see R04
  wire tx_go = en & tx_full & ~tx_busy & (~ctrl[`UFL_CTRL_FLOW] | ~cts_n_in);

  ufl_tx u_tx (
    .clk        (CLOCK),
    .rst_n      (RST_N),
    .bit_tick   (tx_tick),
    .parity_en  (ctrl[`UFL_CTRL_PARITY]),
    .parity_odd (ctrl[`UFL_CTRL_ODD]),
    .stop2      (ctrl[`UFL_CTRL_STOP2]),
    .flow_en    (ctrl[`UFL_CTRL_FLOW]),
    .cts_n      (cts_n_in),
    .load       (tx_go),
    .data       (tx_hold),
    .busy       (tx_busy),
    .done       (tx_done),
    .line       (tx_line)
  );

  ////////////////////////////////////////////////////////////////////////
  // Receiver, sixteen-times oversampled
  localparam RX_IDLE = 2'd0;
  localparam RX_BITS = 2'd1;
  localparam RX_STOP = 2'd2;

  reg  [1:0] rx_state;
  reg  [3:0] rx_ph;
  reg  [3:0] rx_idx;
  reg  [8:0] rx_sh;
  reg        rx_prev;
  reg        rx_evt;
  reg        rx_perr;
  reg        rx_ferr;
  wire [3:0] rx_last = ctrl[`UFL_CTRL_PARITY] ? 4'd9 : 4'd8;

  always @(posedge CLOCK) begin
    if (!RST_N || !en) begin
      rx_state <= RX_IDLE;
      rx_ph    <= 4'h0;
      rx_idx   <= 4'h0;
      rx_sh    <= 9'h000;
      rx_prev  <= 1'b1;
      rx_evt   <= 1'b0;
      rx_perr  <= 1'b0;
      rx_ferr  <= 1'b0;
    end else begin
      rx_evt  <= 1'b0;
      rx_perr <= 1'b0;
      rx_ferr <= 1'b0;
      rx_prev <= rxd_in;
      case (rx_state)
        RX_IDLE: begin
          if (rx_prev && !rxd_in) begin  // see R11
            rx_state <= RX_BITS;
            rx_ph    <= 4'h0;
            rx_idx   <= 4'h0;
          end
        end
        RX_BITS: begin
          if (rx_tick) begin
            rx_ph <= rx_ph + 4'h1;
            if (rx_ph == 4'd7) begin  // see R11
              if (rx_idx == 4'h0 && rxd_in)
                rx_state <= RX_IDLE;
              else if (rx_idx != 4'h0) begin
                rx_sh <= {rxd_in, rx_sh[8:1]};  // see R01
                if (rx_idx == rx_last)
                  rx_state <= RX_STOP;
              end
              rx_idx <= rx_idx + 4'h1;
            end
          end
        end
        RX_STOP: begin
          if (rx_tick) begin
            rx_ph <= rx_ph + 4'h1;
            if (rx_ph == 4'd7) begin
              rx_state <= RX_IDLE;
              rx_evt   <= 1'b1;
              rx_ferr  <= ~rxd_in;
              rx_perr  <= ctrl[`UFL_CTRL_PARITY] &
                          (^rx_sh ^ ctrl[`UFL_CTRL_ODD]);  // see R05
            end
          end
        end
        default: rx_state <= RX_IDLE;
      endcase
    end
  end

  wire [7:0] rx_byte = ctrl[`UFL_CTRL_PARITY] ? rx_sh[7:0] : rx_sh[8:1];

  ////////////////////////////////////////////////////////////////////////
  // Registers, memory access and interrupts
  reg [`UFL_IRQ_W-1:0] ev;
  wire dma_tx_done = dma_tx_on & (tx_cnt == 16'h0000) & ~tx_full & ~tx_busy;
  wire dma_rx_done = dma_rx_on & (rx_cnt == 16'h0000);

  always @* begin
    ev = {`UFL_IRQ_W{1'b0}};
    ev[`UFL_IRQ_TXDONE] = tx_done;
    ev[`UFL_IRQ_RXRDY]  = rx_evt;
    ev[`UFL_IRQ_PARERR] = rx_perr;
    ev[`UFL_IRQ_FRMERR] = rx_ferr;
    ev[`UFL_IRQ_OVRRUN] = rx_evt & rx_full;
    ev[`UFL_IRQ_DMATX]  = dma_tx_done;
    ev[`UFL_IRQ_DMARX]  = dma_rx_done;
  end

  always @(posedge CLOCK) begin
    if (!RST_N) begin
      ctrl      <= `UFL_CTRL_RST;
      baud      <= `UFL_BAUD_RST;
      pinsel    <= `UFL_PINSEL_RST;
      irq_st    <= {`UFL_IRQ_W{1'b0}};
      irq_mask  <= {`UFL_IRQ_W{1'b0}};
      tx_ptr    <= 32'h0000_0000;
      tx_cnt    <= 16'h0000;
      rx_ptr    <= 32'h0000_0000;
      rx_cnt    <= 16'h0000;
      tx_hold   <= 8'h00;
      tx_full   <= 1'b0;
      rx_hold   <= 8'h00;
      rx_full   <= 1'b0;
      dma_tx_on <= 1'b0;
      dma_rx_on <= 1'b0;
      mem_op    <= 2'b00;
      MEM_REQ   <= 1'b0;
      MEM_WE    <= 1'b0;
      MEM_ADDR  <= 32'h0000_0000;
      MEM_WDATA <= 8'h00;
      PRDATA    <= 32'h0000_0000;
      PREADY    <= 1'b0;
      PSLVERR   <= 1'b0;
      IRQ       <= 1'b0;
    end else begin
      PREADY  <= PSEL & PENABLE & ~PREADY;
      PSLVERR <= 1'b0;
      PRDATA  <= 32'h0000_0000;
      if (tx_go)
        tx_full <= 1'b0;
      if (rx_evt && !rx_full) begin
        rx_hold <= rx_byte;
        rx_full <= 1'b1;
      end
      if (dma_tx_done)
        dma_tx_on <= 1'b0;
      if (dma_rx_done)
        dma_rx_on <= 1'b0;
      // Memory path, one byte at a time, see R09
      if (MEM_REQ) begin
        if (MEM_ACK) begin
          MEM_REQ <= 1'b0;
          mem_op  <= 2'b00;
          if (mem_op == 2'b01) begin
            tx_hold <= MEM_RDATA;
            tx_full <= 1'b1;
            tx_ptr  <= tx_ptr + 32'h0000_0001;
            tx_cnt  <= tx_cnt - 16'h0001;
          end else begin
            rx_full <= 1'b0;
            rx_ptr  <= rx_ptr + 32'h0000_0001;
            rx_cnt  <= rx_cnt - 16'h0001;
          end
        end
      end else if (en && dma_rx_on && rx_full && rx_cnt != 16'h0000) begin
        // Receive served first so bytes are not lost
        MEM_REQ   <= 1'b1;
        MEM_WE    <= 1'b1;
        MEM_ADDR  <= rx_ptr;
        MEM_WDATA <= rx_hold;
        mem_op    <= 2'b10;
      end else if (en && dma_tx_on && !tx_full && !tx_go && tx_cnt != 16'h0000) begin
        MEM_REQ  <= 1'b1;
        MEM_WE   <= 1'b0;
        MEM_ADDR <= tx_ptr;
        mem_op   <= 2'b01;
      end
      if (wr) begin
        if (PADDR == `UFL_OFF_CTRL)
          ctrl <= PWDATA[4:0];
        else if (PADDR == `UFL_OFF_BAUD)
          baud <= PWDATA[15:0];
        else if (PADDR == `UFL_OFF_PINSEL)
          pinsel <= PWDATA[7:0];
        else if (PADDR == `UFL_OFF_MASK)
          irq_mask <= PWDATA[`UFL_IRQ_W-1:0];
        else if (PADDR == `UFL_OFF_TXPTR)
          tx_ptr <= PWDATA;
        else if (PADDR == `UFL_OFF_TXCNT)
          tx_cnt <= PWDATA[15:0];
        else if (PADDR == `UFL_OFF_RXPTR)
          rx_ptr <= PWDATA;
        else if (PADDR == `UFL_OFF_RXCNT)
          rx_cnt <= PWDATA[15:0];
        else if (PADDR == `UFL_OFF_TXDATA) begin
          tx_hold <= PWDATA[7:0];
          tx_full <= 1'b1;
        end else if (PADDR == `UFL_OFF_START) begin
          dma_tx_on <= PWDATA[`UFL_START_TX];
          dma_rx_on <= PWDATA[`UFL_START_RX];
        end else if (PADDR != `UFL_OFF_IRQ)
          PSLVERR <= 1'b1;
      end
      if (rd) begin
        if (PADDR == `UFL_OFF_CTRL)
          PRDATA <= {27'h0, ctrl};
        else if (PADDR == `UFL_OFF_BAUD)
          PRDATA <= {16'h0000, baud};
        else if (PADDR == `UFL_OFF_PINSEL)
          PRDATA <= {24'h00_0000, pinsel};
        else if (PADDR == `UFL_OFF_STATUS)
          PRDATA <= {26'h0, dma_rx_on, dma_tx_on, rx_full, tx_full, tx_busy,
                     rx_state != RX_IDLE};
        else if (PADDR == `UFL_OFF_IRQ)
          PRDATA <= {24'h00_0000, irq_st};
        else if (PADDR == `UFL_OFF_MASK)
          PRDATA <= {24'h00_0000, irq_mask};
        else if (PADDR == `UFL_OFF_TXPTR)
          PRDATA <= tx_ptr;
        else if (PADDR == `UFL_OFF_TXCNT)
          PRDATA <= {16'h0000, tx_cnt};
        else if (PADDR == `UFL_OFF_RXPTR)
          PRDATA <= rx_ptr;
        else if (PADDR == `UFL_OFF_RXCNT)
          PRDATA <= {16'h0000, rx_cnt};
        else if (PADDR == `UFL_OFF_RXDATA) begin
          PRDATA  <= {24'h00_0000, rx_hold};
          rx_full <= 1'b0;
        end else if (PADDR != `UFL_OFF_TXDATA && PADDR != `UFL_OFF_START)
          PSLVERR <= 1'b1;
      end
      // New events win over a write-one clear
      if (wr && PADDR == `UFL_OFF_IRQ)
        irq_st <= (irq_st & ~PWDATA[`UFL_IRQ_W-1:0]) | ev;
      else
        irq_st <= irq_st | ev;
      IRQ <= |(irq_st & irq_mask);
    end
  end

endmodule // ufl_top

`default_nettype wire

// >>> sim/ufl_chk_asserts.sv
`timescale 1ns/10ps
`default_nettype none
module ufl_chk (
  input wire logic        CLOCK,
  input wire logic        RST_N,
  input wire logic        PSEL,
  input wire logic        PENABLE,
  input wire logic        PWRITE,
  input wire logic        PREADY,
  input wire logic        PSLVERR,
  input wire logic        IRQ,
  input wire logic [3:0]  PIN_OUT,
  input wire logic [3:0]  PIN_OE,
  input wire logic        MEM_REQ,
  input wire logic        MEM_ACK,
  input wire logic [31:0] MEM_ADDR
);
  default clocking @(posedge CLOCK); endclocking
  default disable iff (!RST_N);
  ////////////////////////////////////////
  AST_APB_ONE_WAIT: assert property (PSEL && PENABLE && !PREADY |=> PREADY)
    else $error("access not answered after one wait state");
  AST_APB_PULSE: assert property (PREADY |=> !PREADY)
    else $error("ready held longer than one cycle");
  AST_SLVERR_PAIR: assert property (PSLVERR |-> PREADY)
    else $error("error flag without ready");
  AST_PINS_IDLE: assert property ($rose(RST_N) |-> PIN_OE == 4'h0)
    else $error("pins driven right after reset");
  // Any low level on the driven pin 0 lasts at least 8 cycles
  AST_BIT_MIN_LEN: assert property ($fell(PIN_OUT[0]) && PIN_OE[0] |-> !PIN_OUT[0] [*8])
    else $error("transmit low level too short");
  AST_MEM_HOLD: assert property (MEM_REQ && !MEM_ACK |=> MEM_REQ && $stable(MEM_ADDR))
    else $error("memory request dropped or moved before ack");
  AST_MEM_RELEASE: assert property (MEM_REQ && MEM_ACK |=> !MEM_REQ)
    else $error("memory request kept after ack");
  // Status bits are sticky, so the line only drops after a register write
  AST_IRQ_CAUSE: assert property ($fell(IRQ) |-> $past(PSEL && PENABLE && PWRITE, 1)
    || $past(PSEL && PENABLE && PWRITE, 2))
    else $error("interrupt dropped without a write");
endmodule  // ufl_chk
bind ufl_top ufl_chk ufl_chk_i (.CLOCK, .RST_N, .PSEL, .PENABLE, .PWRITE, .PREADY, .PSLVERR,
  .IRQ, .PIN_OUT, .PIN_OE, .MEM_REQ, .MEM_ACK, .MEM_ADDR);
`default_nettype wire

// >>> sim/ufl_far_port.sv
`timescale 1ns/10ps
`default_nettype none
module ufl_far_port #(
  parameter int BITS = 100
) (
  input  wire logic clk,
  input  wire logic rx_line,
  input  wire logic rts_n,
  input  wire logic par_en,
  input  wire logic hold,
  output var  logic tx_line,
  output wire logic cts_n
);
  int         count = 0;
  logic [7:0] last_byte;
  logic       last_par;
  assign cts_n = hold;
  initial tx_line = 1'b1;
  ////////////////////////////////////////
  // Same fixed rate as the port, sampled mid-bit
  initial forever begin : rx_proc
    @(posedge clk);
    if (rx_line === 1'b0) begin
      repeat (BITS / 2) @(posedge clk);
      for (int i = 0; i < 8; i++) begin
        repeat (BITS) @(posedge clk);
        last_byte[i] = rx_line;
      end
      if (par_en) begin
        repeat (BITS) @(posedge clk);
        last_par = rx_line;
      end
      repeat (BITS) @(posedge clk);
      count++;
    end
  end
  ////////////////////////////////////////
  // Even parity; bad flips it on purpose
  task send(input logic [7:0] d, input logic bad);
    logic [10:0] f;
    int          n;
    f = {1'b1, ^d ^ bad, d, 1'b0};
    n = 0;
    while (rts_n !== 1'b0 && n < 5000) begin
      @(posedge clk);
      n++;
    end
    for (int i = 0; i < 11; i++) begin
      if (i != 9 || par_en) begin
        tx_line <= f[i];
        repeat (BITS) @(posedge clk);
      end
    end
  endtask
endmodule  // ufl_far_port
`default_nettype wire

// >>> sim/ufl_tb.sv
`timescale 1ns/10ps
`default_nettype none
`include "ufl_consts.vh"
`define CHK(n, x, s) begin check_count++; if ((x) !== (s)) begin errors++; \
  $display("unexpected %s exp %h got %h", n, x, s); end end
module testbench;
  typedef struct packed {logic [11:0] a; logic [31:0] d; logic e;} ufl_row_t;
  logic        CLOCK = 0, RST_N = 0, PSEL = 0, PENABLE = 0, PWRITE = 0, MEM_ACK = 0;
  logic [11:0] PADDR = 0;
  logic [31:0] PWDATA = 0, PRDATA, MEM_ADDR, q;
  logic [7:0]  MEM_RDATA = 0, MEM_WDATA;
  logic [3:0]  PIN_IN, PIN_OUT, PIN_OE;
  logic        PREADY, PSLVERR, IRQ, MEM_REQ, MEM_WE, e, far_tx, far_cts_n, tx_w, rts_w;
  logic        far_hold = 0, par_en = 0;
  logic [7:0]  stored = 0;
  int          errors = 0, check_count = 0;
  ufl_row_t    rows [6] = '{{`UFL_OFF_CTRL, 32'h0000_0000, 1'b0},
    {`UFL_OFF_BAUD, 32'h0000_0364, 1'b0}, {`UFL_OFF_PINSEL, 32'h0000_00E4, 1'b0},
    {`UFL_OFF_IRQ, 32'h0000_0000, 1'b0}, {`UFL_OFF_START, 32'h0000_0000, 1'b0},
    {12'h040, 32'h0000_0000, 1'b1}};
  always #5 CLOCK = ~CLOCK;
  // Released pins float high through pull-ups
  assign tx_w   = PIN_OE[0] ? PIN_OUT[0] : 1'b1;
  assign rts_w  = PIN_OE[2] ? PIN_OUT[2] : 1'b1;
  assign PIN_IN = {far_cts_n, rts_w, far_tx, tx_w};
  always @(posedge CLOCK) begin
    MEM_ACK   <= MEM_REQ & ~MEM_ACK;
    MEM_RDATA <= MEM_ADDR[7:0] ^ 8'h5A;
    if (MEM_REQ && MEM_ACK && MEM_WE) stored <= MEM_WDATA;
  end
  ufl_top ufl_top_i (.CLOCK(CLOCK), .RST_N(RST_N), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
    .PSLVERR(PSLVERR), .IRQ(IRQ), .PIN_IN(PIN_IN), .PIN_OUT(PIN_OUT), .PIN_OE(PIN_OE),
    .MEM_REQ(MEM_REQ), .MEM_WE(MEM_WE), .MEM_ADDR(MEM_ADDR), .MEM_WDATA(MEM_WDATA),
    .MEM_RDATA(MEM_RDATA), .MEM_ACK(MEM_ACK));
  ufl_far_port #(.BITS(100)) ufl_far_port_i (.clk(CLOCK), .rx_line(tx_w), .rts_n(rts_w),
    .par_en(par_en), .hold(far_hold), .tx_line(far_tx), .cts_n(far_cts_n));
  ////////////////////////////////////////
  task tally_and_finish;
    $display("checks %0d mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    PSEL <= 1;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge CLOCK);
    PENABLE <= 1;
    n = 0;
    do begin
      @(posedge CLOCK);
      n++;
    end while (PREADY !== 1'b1 && n < 20);
    if (PREADY !== 1'b1) begin
      errors++;
      tally_and_finish();
    end
    q = PRDATA;
    e = PSLVERR;
    PSEL <= 0;
    PENABLE <= 0;
    @(posedge CLOCK);
  endtask
  task wait_until(input logic on_irq, input int c);
    int n;
    n = 0;
    while ((on_irq ? IRQ !== 1'b1 : ufl_far_port_i.count != c) && n < 30000) begin
      @(posedge CLOCK);
      n++;
    end
    if (n >= 30000) begin
      errors++;
      tally_and_finish();
    end
  endtask
  ////////////////////////////////////////
  initial begin
    repeat (4) @(posedge CLOCK);
    RST_N <= 1;
    @(posedge CLOCK);
    foreach (rows[i]) begin
      apb(0, rows[i].a, 0);
      `CHK("slverr", rows[i].e, e)
      if (!rows[i].e) `CHK("reset value", rows[i].d, q)
    end
    `CHK("oe disabled", 4'h0, PIN_OE)
    $display("reset values done");
    apb(1, `UFL_OFF_PINSEL, 32'h0000_00E4);
    apb(1, `UFL_OFF_BAUD, 32'h0000_0064);
    apb(1, `UFL_OFF_MASK, 32'h0000_007F);
    apb(1, `UFL_OFF_CTRL, 32'h0000_0007);
    par_en <= 1;
    `CHK("oe enabled", 4'h5, PIN_OE)
    `CHK("rts empty", 1'b0, PIN_OUT[2])
    far_hold <= 1;
    apb(1, `UFL_OFF_TXDATA, 32'h0000_00A5);
    repeat (300) @(posedge CLOCK);
    `CHK("held frames", 0, ufl_far_port_i.count)
    far_hold <= 0;
    wait_until(0, 1);
    `CHK("tx byte", 8'hA5, ufl_far_port_i.last_byte)
    `CHK("tx parity", ^8'hA5, ufl_far_port_i.last_par)
    $display("flow control done");
    fork
      ufl_far_port_i.send(8'h3C, 0);
      apb(1, `UFL_OFF_TXDATA, 32'h0000_00C3);
    join
    wait_until(0, 2);
    repeat (200) @(posedge CLOCK);
    `CHK("tx byte 2", 8'hC3, ufl_far_port_i.last_byte)
    apb(0, `UFL_OFF_IRQ, 0);
    `CHK("rx ready", 1'b1, q[1])
    `CHK("rts full", 1'b1, PIN_OUT[2])
    apb(0, `UFL_OFF_RXDATA, 0);
    `CHK("rx byte", 8'h3C, q[7:0])
    `CHK("rts freed", 1'b0, PIN_OUT[2])
    apb(1, `UFL_OFF_IRQ, 32'h0000_007F);
    apb(0, `UFL_OFF_IRQ, 0);
    `CHK("irq cleared", 32'h0000_0000, q)
    `CHK("irq line low", 1'b0, IRQ)
    $display("full duplex done");
    ufl_far_port_i.send(8'h3C, 1);
    wait_until(1, 0);
    apb(0, `UFL_OFF_IRQ, 0);
    `CHK("parity error", 1'b1, q[2])
    apb(1, `UFL_OFF_MASK, 32'h0000_0000);
    `CHK("irq masked", 1'b0, IRQ)
    apb(1, `UFL_OFF_MASK, 32'h0000_007F);
    `CHK("irq unmasked", 1'b1, IRQ)
    apb(1, `UFL_OFF_IRQ, 32'h0000_007F);
    apb(0, `UFL_OFF_RXDATA, 0);
    $display("parity done");
    apb(1, `UFL_OFF_TXPTR, 32'h0000_0100);
    apb(1, `UFL_OFF_TXCNT, 32'h0000_0002);
    apb(1, `UFL_OFF_START, 32'h0000_0001);
    wait_until(0, 4);
    `CHK("dma byte", 8'h5B, ufl_far_port_i.last_byte)
    apb(1, `UFL_OFF_RXPTR, 32'h0000_0200);
    apb(1, `UFL_OFF_RXCNT, 32'h0000_0001);
    apb(1, `UFL_OFF_START, 32'h0000_0002);
    ufl_far_port_i.send(8'h96, 0);
    repeat (200) @(posedge CLOCK);
    `CHK("dma store", 8'h96, stored)
    apb(0, `UFL_OFF_IRQ, 0);
    `CHK("dma rx done", 1'b1, q[6])
    $display("dma done");
    tally_and_finish();
  end
endmodule  // testbench
`default_nettype wire
